// [dwscc_core.sv]
// Serial command interpreter for a two channel wiper device.
// Assumes serial pins are asynchronous to ref_clk and much slower.
`timescale 1ns/1ns
`include "dwscc_consts.svh"
module dwscc_core
  import dwscc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic wp_n,
  output logic sdo_o,
  output logic sdo_oe,
  output logic rb_o,
  output logic rb_oe,
  output logic standby,
  output dwscc_chan_type ch0_state,
  output dwscc_chan_type ch1_state
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Only codes 00 and 01 name a channel
  function automatic logic chan_ok(input logic [1:0] idx);
    chan_ok = (idx[1] == 1'b0);
  endfunction : chan_ok
  // One step with saturation at both ends
  function automatic logic [7:0] step(input logic [7:0] pos, input logic up);
    if (up) begin
      step = (pos == `WIPER_MAX) ? pos : pos + 8'h01;
    end else begin
      step = (pos == `WIPER_MIN) ? pos : pos - 8'h01;
    end
  endfunction : step

  localparam logic [5:0] ACC_LOAD = 6'(`ACCESS_CYCLES - 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sclk_s1, sclk_s2, sclk_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic sdi_s1, sdi_s2;
  logic wp_s1, wp_s2;

  // Two flops per pin, third stage only for edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {sdi_s1, sdi_s2} <= 2'h0;
      {wp_s1, wp_s2} <= 2'h0;
    end else begin
      {sclk_s1, sclk_s2, sclk_s3} <= {link_clk, sclk_s1, sclk_s2};
      {cs_s1, cs_s2, cs_s3} <= {cs_n, cs_s1, cs_s2};
      {sdi_s1, sdi_s2} <= {sdi, sdi_s1};
      {wp_s1, wp_s2} <= {wp_n, wp_s1};
    end
  end

  // Edge strobes
  wire sclk_rise = sclk_s2 & ~sclk_s3;
  wire sclk_fall = ~sclk_s2 & sclk_s3;
  wire cs_fall = ~cs_s2 & cs_s3;
  wire cs_rise = cs_s2 & ~cs_s3;
  wire selected = ~cs_s2;
  wire guard_off = wp_s2;

  // ----------------------------------------
  // State
  // ----------------------------------------
  dwscc_state_type state_reg, state_next;
  dwscc_cmd_type cmd_reg;
  logic [23:0] shift_reg, shift_next;
  logic [4:0] bit_cnt_reg;
  logic full_reg, armed_reg, asleep_reg, rb_low_reg;
  logic sdo_reg, standby_reg;
  logic [5:0] acc_cnt_reg;
  logic [1:0][8:0] wiper_reg;
  logic [1:0][3:0][8:0] preset_store;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  dwscc_cmd_type frame;
  assign frame = dwscc_cmd_type'(shift_reg);
  wire [3:0] op = frame.opcode_field;
  wire idle = (state_reg == ST_IDLE);
  // Whole frame of 24n bits at select rise
  wire frame_done = cs_rise & armed_reg & full_reg
    & (bit_cnt_reg == `BIT_ZERO) & idle;
  // Asleep: wake only
  wire take = frame_done & (~asleep_reg | (op == `OP_WAKE));
  wire needs_access = (op == `OP_RD_WIPER) | (op == `OP_RD_PRESET)
    | (op == `OP_PROG) | (op == `OP_LOAD) | (op == `OP_SAVE)
    | (op == `OP_ERASE);
  wire flow_cmd = needs_access & (op != `OP_ERASE);
  wire imm = take & ~needs_access;
  wire ch_sel = frame.channel_index[0];
  wire imm_ok = imm & chan_ok(frame.channel_index);
  // Access completion and its target
  wire acc_done = (state_reg == ST_ACCESS) & (acc_cnt_reg == 6'h00);
  wire [3:0] aop = cmd_reg.opcode_field;
  wire a_ch = cmd_reg.channel_index[0];
  wire [1:0] a_slot = cmd_reg.preset_slot_index;
  wire a_ok = acc_done & chan_ok(cmd_reg.channel_index);
  wire [8:0] slot_word = preset_store[a_ch][a_slot];
  // Preset change allowed only with guard released
  wire pre_wr = a_ok & guard_off & ((aop == `OP_PROG) | (aop == `OP_SAVE)
    | (aop == `OP_ERASE));
  wire [8:0] pre_val = (aop == `OP_PROG) ? cmd_reg.data_field :
    (aop == `OP_SAVE) ? wiper_reg[a_ch] : `ERASE_VALUE;
  wire rd_hit = a_ok & ((aop == `OP_RD_WIPER) | (aop == `OP_RD_PRESET));
  wire [8:0] rd_val = (aop == `OP_RD_WIPER) ? wiper_reg[a_ch] : slot_word;
  wire [23:0] rd_frame = {cmd_reg.opcode_field, cmd_reg.preset_slot_index,
    cmd_reg.channel_index, 7'h00, rd_val};

  // ----------------------------------------
  // Serial shifter
  // ----------------------------------------
  // Read answer replaces held frame for the next shift out
  assign shift_next = rd_hit ? rd_frame :
    (sclk_rise & selected) ? {shift_reg[22:0], sdi_s2} : shift_reg;

  // Shift register and bit counter
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift_reg <= 24'h000000;
      bit_cnt_reg <= `BIT_ZERO;
      full_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      if (cs_fall) begin
        bit_cnt_reg <= `BIT_ZERO;
        full_reg <= 1'b0;
      end else if (sclk_rise & selected) begin
        bit_cnt_reg <= (bit_cnt_reg == `BIT_LAST) ? `BIT_ZERO : bit_cnt_reg + 5'h01;
        full_reg <= full_reg | (bit_cnt_reg == `BIT_LAST);
      end
    end
  end

  // Data out bit: first at select fall, later at clock falls
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sdo_reg <= 1'b1;
    end else if (cs_fall | (sclk_fall & selected)) begin
      sdo_reg <= shift_reg[23];
    end
  end

  // Open drain: pull low only while selected
  assign sdo_o = 1'b0;
  assign sdo_oe = selected & ~sdo_reg;

  // ----------------------------------------
  // Control
  // ----------------------------------------
  // Start of operation needs a select fall after reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      armed_reg <= 1'b0;
    end else if (cs_fall) begin
      armed_reg <= 1'b1;
    end
  end

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_STARTUP: state_next = ST_IDLE;
      ST_IDLE: begin
        if (take & needs_access) begin
          state_next = ST_ACCESS;
        end else if (imm & (op == `OP_SWRST)) begin
          state_next = ST_STARTUP;
        end
      end
      ST_ACCESS: begin
        if (acc_done) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_STARTUP;
    endcase
  end

  // State, latched command and access timer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_STARTUP;
      cmd_reg <= '0;
      acc_cnt_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      if (take & needs_access) begin
        cmd_reg <= frame;
        acc_cnt_reg <= ACC_LOAD;
      end else if (state_reg == ST_ACCESS) begin
        acc_cnt_reg <= acc_cnt_reg - 6'h01;
      end
    end
  end

  // Sleep flag: set by reset, soft reset and sleep
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      asleep_reg <= 1'b1;
    end else if (state_reg == ST_STARTUP) begin
      asleep_reg <= 1'b1;
    end else if (imm) begin
      if (op == `OP_SLEEP) begin
        asleep_reg <= 1'b1;
      end else if (op == `OP_WAKE) begin
        asleep_reg <= 1'b0;
      end
    end
  end

  // Busy: low from end of flow command to end of access or next select fall
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rb_low_reg <= 1'b0;
    end else if (take & flow_cmd) begin
      rb_low_reg <= 1'b1;
    end else if (cs_fall | acc_done) begin
      rb_low_reg <= 1'b0;
    end
  end

  assign rb_o = 1'b0;
  assign rb_oe = rb_low_reg;

  // Standby when deselected with no access running
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      standby_reg <= 1'b1;
    end else begin
      standby_reg <= cs_s2 & (state_next != ST_ACCESS);
    end
  end
  assign standby = standby_reg;

  // ----------------------------------------
  // Wipers and presets
  // ----------------------------------------
  // Wiper updates; each channel independent
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wiper_reg <= {2{`PRESET_INIT}};
    end else if (state_reg == ST_STARTUP) begin
      wiper_reg[0] <= preset_store[0][`DEFAULT_SLOT];
      wiper_reg[1] <= preset_store[1][`DEFAULT_SLOT];
    end else if (imm_ok & (op == `OP_WR_WIPER)) begin
      wiper_reg[ch_sel][7:0] <= frame.data_field[7:0];
    end else if (imm_ok & ((op == `OP_UP) | (op == `OP_DOWN))) begin
      wiper_reg[ch_sel][7:0] <= step(wiper_reg[ch_sel][7:0], op == `OP_UP);
    end else if (a_ok & (aop == `OP_LOAD)) begin
      wiper_reg[a_ch] <= slot_word;
    end
  end

  // Preset store, written after the access cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      preset_store <= {8{`PRESET_INIT}};
    end else if (pre_wr) begin
      preset_store[a_ch][a_slot] <= pre_val;
    end
  end

  // Bit 8 drives each channel's buffer enable
  assign ch0_state = dwscc_chan_type'(wiper_reg[0]);
  assign ch1_state = dwscc_chan_type'(wiper_reg[1]);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int ACC_WAIT = `ACCESS_CYCLES + 2;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence busy_start;
    take & flow_cmd;
  endsequence
  sequence busy_run;
    ##1 rb_oe ##[1:ACC_WAIT] !rb_oe;
  endsequence

  AST_SDO_OFF: assert property (cs_s2 |-> !sdo_oe)
    else $error("data out driven while deselected");
  AST_FIRST_BIT: assert property (cs_fall |=> sdo_reg == $past(shift_reg[23]))
    else $error("first bit not shown at select fall");
  AST_SAMPLE: assert property (sclk_rise & selected & !rd_hit
    |=> shift_reg[0] == $past(sdi_s2))
    else $error("serial bit not captured");
  AST_BUSY: assert property (busy_start |-> busy_run)
    else $error("busy not held over access");
  AST_RB_RELEASE: assert property (cs_fall |=> !rb_oe)
    else $error("busy not released at select fall");
  AST_GUARD: assert property (acc_done & !guard_off |=> $stable(preset_store))
    else $error("preset changed under guard");
  AST_SLEEP: assert property (frame_done & asleep_reg & op != `OP_WAKE
    |=> $stable(wiper_reg) && state_reg == ST_IDLE)
    else $error("command taken while asleep");
  AST_STARTUP: assert property (state_reg == ST_STARTUP
    |=> wiper_reg[1] == $past(preset_store[1][`DEFAULT_SLOT]))
    else $error("default preset not loaded");
  AST_ARM: assert property (!armed_reg |-> !take)
    else $error("command without select fall");
  AST_KEEP_BUF: assert property (imm_ok & op == `OP_WR_WIPER
    |=> $stable(wiper_reg[0][8]) && $stable(wiper_reg[1][8]))
    else $error("direct write changed buffer select");
  AST_SAT_UP: assert property (imm_ok & op == `OP_UP & !ch_sel
    & wiper_reg[0][7:0] == `WIPER_MAX |=> wiper_reg[0][7:0] == `WIPER_MAX)
    else $error("increment wrapped");
endmodule : dwscc_core

// [dwscc_consts.svh]
// Constants for the dual wiper serial command block.
// Assumes inclusion by the package and the block module.
`ifndef DWSCC_CONSTS_SVH
`define DWSCC_CONSTS_SVH
// ----------------------------------------
// Opcodes
// ----------------------------------------
`define OP_NOP 4'h0
`define OP_RD_WIPER 4'hC
`define OP_WR_WIPER 4'h4
`define OP_RD_PRESET 4'hA
`define OP_PROG 4'h2
`define OP_LOAD 4'hB
`define OP_SAVE 4'h3
`define OP_UP 4'h7
`define OP_DOWN 4'hF
`define OP_SLEEP 4'h8
`define OP_WAKE 4'h1
`define OP_ERASE 4'hD
`define OP_SWRST 4'h9
// ----------------------------------------
// Values and timing
// ----------------------------------------
`define BIT_LAST 5'h17
`define BIT_ZERO 5'h00
`define WIPER_MAX 8'hFF
`define WIPER_MIN 8'h00
`define PRESET_INIT 9'h080
`define ERASE_VALUE 9'h1FF
`define DEFAULT_SLOT 2'h0
`define CLK_PERIOD_NS 10
`define ACCESS_TIME_NS 500
`define ACCESS_CYCLES ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [dwscc_pkg.sv]
// Types shared by the dual wiper serial command block.
// Assumes the constants header sits in the same folder.
`include "dwscc_consts.svh"
package dwscc_pkg;
  // 24-bit command frame, first bit sent is the top bit
  typedef struct packed {
    logic [3:0] opcode_field;
    logic [1:0] preset_slot_index;
    logic [1:0] channel_index;
    logic [6:0] spare_bits;
    logic [8:0] data_field;
  } dwscc_cmd_type;
  // One channel as seen by the analog side
  typedef struct packed {
    logic buffer_select_bit;
    logic [7:0] position;
  } dwscc_chan_type;
  typedef enum logic [1:0] {ST_STARTUP, ST_IDLE, ST_ACCESS} dwscc_state_type;
endpackage : dwscc_pkg

// [dwscc_host.sv]
// Host model that drives the serial command link of the wiper block.
// Assumes data out and busy are pulled-up open-drain lines.
`timescale 1ns/1ns
module dwscc_host (
  output logic link_clk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_line,
  input wire logic rb_line
);
  logic got[$];
  // ----------------------------------------
  // Idle levels
  // ----------------------------------------
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Sends one frame MSB first; the clock stands still outside frames
  task automatic send(input logic [47:0] bits, input int n);
    got.delete();
    cs_n = 1'b0;
    #63;
    for (int i = n - 1; i >= 0; i--) begin
      sdi = bits[i];
      #62;
      got.push_back(sdo_line);
      link_clk = 1'b1;
      #63;
      link_clk = 1'b0;
    end
    #63;
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask : send
  // Polls the busy line after every command, bounded
  task automatic poll(output logic busy_seen);
    busy_seen = 1'b0;
    for (int i = 0; i < 150; i++) begin
      #10;
      if (rb_line === 1'b0) begin
        busy_seen = 1'b1;
      end else if (busy_seen) begin
        break;
      end
    end
  endtask : poll
endmodule : dwscc_host

// [tb.sv]
// Self-checking bench for the wiper command block with a reference model.
// Assumes the host model and the block sit in this folder.
`timescale 1ns/1ns
`include "dwscc_consts.svh"
module tb
  import dwscc_pkg::*;
;
  logic ref_clk, resetn, wp_n, link_clk, cs_n, sdi;
  logic sdo_o, sdo_oe, rb_o, rb_oe, standby, sdo_line, rb_line;
  dwscc_chan_type ch0_state, ch1_state;
  logic [8:0] wip [2];
  logic [8:0] pre [2][4];
  logic [23:0] h;
  logic [3:0] ops [13];
  bit awake;
  int mismatches, checked, cycles;
  // Pull-ups on both open-drain lines
  assign sdo_line = sdo_oe ? sdo_o : 1'b1;
  assign rb_line = rb_oe ? rb_o : 1'b1;
  // ----------------------------------------
  // Instances
  // ----------------------------------------
  dwscc_core dut (.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .cs_n(cs_n),
    .sdi(sdi), .wp_n(wp_n), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .rb_o(rb_o), .rb_oe(rb_oe),
    .standby(standby), .ch0_state(ch0_state), .ch1_state(ch1_state));
  dwscc_host host (.link_clk(link_clk), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line),
    .rb_line(rb_line));
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // Reference model of one executed command
  task automatic apply(input logic [23:0] c);
    int s;
    int k;
    s = c[19:18];
    k = c[16];
    if (c[17] && !(c[23:20] inside {`OP_SLEEP, `OP_WAKE, `OP_SWRST, `OP_NOP})) begin
      return;
    end
    case (c[23:20])
      `OP_RD_WIPER: h = {c[23:16], 7'h00, wip[k]};
      `OP_WR_WIPER: wip[k][7:0] = c[7:0];
      `OP_RD_PRESET: h = {c[23:16], 7'h00, pre[k][s]};
      `OP_PROG: if (wp_n) pre[k][s] = c[8:0];
      `OP_LOAD: wip[k] = pre[k][s];
      `OP_SAVE: if (wp_n) pre[k][s] = wip[k];
      `OP_UP: if (wip[k][7:0] != `WIPER_MAX) wip[k][7:0] = wip[k][7:0] + 8'h01;
      `OP_DOWN: if (wip[k][7:0] != `WIPER_MIN) wip[k][7:0] = wip[k][7:0] - 8'h01;
      `OP_SLEEP: awake = 0;
      `OP_WAKE: awake = 1;
      `OP_ERASE: if (wp_n) pre[k][s] = `ERASE_VALUE;
      `OP_SWRST: begin
        wip[0] = pre[0][0];
        wip[1] = pre[1][0];
        awake = 0;
      end
      default: ;
    endcase
  endtask : apply
  // One frame on the link, then every result compared with the model
  task automatic frame(input logic [47:0] bits, input int n);
    logic [23:0] c;
    logic busy;
    bit go, flow;
    c = bits[23:0];
    go = (n % 24 == 0) && (awake || c[23:20] == `OP_WAKE);
    flow = go && c[23:20] inside {`OP_RD_WIPER, `OP_RD_PRESET, `OP_LOAD, `OP_PROG, `OP_SAVE};
    fork
      host.send(bits, n);
      begin
        #500;
        chk("standby", standby, 0);
      end
    join
    for (int i = 0; i < n; i++) begin
      chk("sdo", host.got[i], h[23]);
      h = {h[22:0], bits[n - 1 - i]};
    end
    host.poll(busy);
    chk("busy", busy, flow);
    if (go) apply(c);
    repeat (60) @(negedge ref_clk);
    chk("ch0", ch0_state, wip[0]);
    chk("ch1", ch1_state, wip[1]);
    chk("standby", standby, 1);
    chk("sdo idle", sdo_line, 1);
  endtask : frame
  task automatic cmd(input logic [3:0] op, input logic [1:0] sl, input logic [1:0] ch,
    input logic [8:0] d);
    frame({24'h000000, op, sl, ch, 7'h00, d}, 24);
  endtask : cmd
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    ops = '{`OP_NOP, `OP_RD_WIPER, `OP_WR_WIPER, `OP_RD_PRESET, `OP_PROG, `OP_LOAD,
      `OP_SAVE, `OP_UP, `OP_DOWN, `OP_SLEEP, `OP_WAKE, `OP_ERASE, `OP_SWRST};
    foreach (pre[k, s]) pre[k][s] = `PRESET_INIT;
    wip = '{`PRESET_INIT, `PRESET_INIT};
    h = 24'h000000; // Holder starts at its reset value
    void'($urandom(96480));
    resetn = 1'b0;
    wp_n = 1'b1;
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    chk("ch0", ch0_state, `PRESET_INIT);
    cmd(`OP_WR_WIPER, 0, 0, 9'h055);
    cmd(`OP_WAKE, 0, 0, 0);
    cmd(`OP_WR_WIPER, 0, 0, 9'h1FF);
    cmd(`OP_UP, 0, 0, 0);
    cmd(`OP_WR_WIPER, 0, 1, 9'h000);
    cmd(`OP_DOWN, 0, 1, 0);
    cmd(`OP_WR_WIPER, 0, 2, 9'h033);
    cmd(`OP_PROG, 1, 0, 9'h1AB);
    cmd(`OP_LOAD, 1, 0, 0);
    wp_n = 1'b0;
    cmd(`OP_PROG, 1, 0, 9'h011);
    cmd(`OP_ERASE, 1, 0, 0);
    cmd(`OP_RD_PRESET, 1, 0, 0);
    cmd(`OP_LOAD, 1, 0, 0);
    wp_n = 1'b1;
    cmd(`OP_SAVE, 0, 0, 0);
    cmd(`OP_ERASE, 0, 1, 0);
    frame({24'h440000 | 24'h000044, 24'h410000 | 24'h000022}, 48);
    frame(48'h000000_4100AA, 23);
    cmd(`OP_SLEEP, 0, 0, 0);
    cmd(`OP_UP, 0, 1, 0);
    cmd(`OP_WAKE, 0, 0, 0);
    cmd(`OP_SWRST, 0, 0, 0);
    cmd(`OP_WAKE, 0, 0, 0);
    repeat (60) begin
      wp_n = ($urandom % 4) != 0;
      cmd(ops[$urandom % 13], 2'($urandom % 4), 2'($urandom % 2), 9'($urandom));
    end
    give_verdict();
  end
endmodule : tb
